// [ddilcs_pkg.sv]
`default_nettype none
package ddilcs_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int FIFO_HOLD_NS  = 100;
	localparam int FIFO_HOLD_CYC = (FIFO_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PLL_LOCK_US   = 30;
	localparam int PLL_LOCK_CYC  = (PLL_LOCK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOCK_CW       = 10;
	localparam int HOLD_CW       = 4;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_PWR_MUX  = 6'h07;
	localparam logic [5:0] IDX_C_BACKUP = 6'h23;
	localparam logic [5:0] IDX_VCO_BR   = 6'h26;
	localparam logic [5:0] IDX_LANE_DIV = 6'h27;
	localparam logic [5:0] IDX_DISP_MUX = 6'h28;
	localparam logic [5:0] IDX_L47      = 6'h2A;
	localparam logic [5:0] IDX_L811     = 6'h2B;
	localparam logic [5:0] IDX_REF_DIV  = 6'h2F;
	localparam logic [5:0] IDX_STATUS   = 6'h30;

	// Storage slots
	localparam logic [2:0] SLOT_PWR_MUX  = 3'h0;
	localparam logic [2:0] SLOT_C_BACKUP = 3'h1;
	localparam logic [2:0] SLOT_VCO_BR   = 3'h2;
	localparam logic [2:0] SLOT_LANE_DIV = 3'h3;
	localparam logic [2:0] SLOT_DISP_MUX = 3'h4;
	localparam logic [2:0] SLOT_L47      = 3'h5;
	localparam logic [2:0] SLOT_L811     = 3'h6;
	localparam logic [2:0] SLOT_REF_DIV  = 3'h7;
	localparam int         NUM_SLOTS     = 8;

	localparam logic [31:0] RST_DISP_MUX = 32'h00000003;
	localparam logic [31:0] RST_OTHER    = 32'h00000000;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int TX_EN_BIT      = 4;
	localparam int PLL_ON_BIT     = 26;
	localparam int HALVE_BIT      = 27;
	localparam int BYPASS_BIT     = 28;
	localparam int G1_INCOH_LSB   = 28;
	localparam int G2_INCOH_LSB   = 14;
	localparam int BRANCH0_BIT    = 22;
	localparam int FORCE_G1_BIT   = 0;
	localparam int FORCE_G2_BIT   = 1;
	localparam int FIFO_WRST_BIT  = 2;
	localparam int REF_SRC_LSB    = 8;
	localparam int WCLK_PICK_BIT  = 12;
	localparam int STAGE0_BIT     = 16;
	localparam int STAGE1_G1_BIT  = 19;
	localparam int STAGE1_G2_BIT  = 20;
	localparam int LANE7_PICK_BIT = 25;
	localparam int LANE11_PICK_BIT = 26;
	localparam int STAGE2_G1_BIT  = 5;
	localparam int STAGE2_G2_BIT  = 6;
	localparam int STAGE2_G3_BIT  = 7;
	localparam int G1_TXSRC_LSB   = 22;
	localparam int G2_TXSRC_LSB   = 24;
	localparam int RCLK_LSB       = 26;

	// Field codes
	localparam logic [2:0] INCOH_DISPLAY = 3'h4;
	localparam logic [2:0] INCOH_CORE    = 3'h0;
	localparam logic [1:0] TXSRC_PLL_B   = 2'h3;
	localparam logic [1:0] TXSRC_PLL_C   = 2'h2;
	localparam logic [2:0] RCLK_PLL_B    = 3'h2;
	localparam logic [1:0] FIFO_RST_ON   = 2'h3;
	localparam logic [1:0] FIFO_RST_OFF  = 2'h0;

	typedef enum logic [1:0] {
		FIFO_IDLE  = 2'b00,
		FIFO_HELD  = 2'b01,
		FIFO_READY = 2'b10
	} ddilcs_fifo_state_type;
endpackage
`default_nettype wire

// [ddilcs_top.sv]
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ddilcs_top
	import ddilcs_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              mclk_i,
	input  wire logic              rstn_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	output logic                   grp1_tx_bypass_enable_o,
	output logic                   grp2_tx_bypass_enable_o,
	output logic                   grp1_incoh_display_o,
	output logic                   grp1_incoh_core_o,
	output logic                   grp2_incoh_display_o,
	output logic                   grp2_incoh_core_o,
	output logic                   grp1_clock_halve_mode_o,
	output logic                   grp2_clock_halve_mode_o,
	output logic                   lane_seven_link_clock_pick_o,
	output logic                   lane_eleven_link_clock_pick_o,
	output logic                   grp1_tx_from_pll_o,
	output logic                   grp2_tx_from_pll_o,
	output logic                   grp1_pll_power_on_o,
	output logic                   grp2_pll_power_on_o,
	output logic                   grp1_channel1_fed_o,
	output logic                   grp2_channel1_fed_o,
	output logic                   grp1_display_traffic_o,
	output logic                   grp2_display_traffic_o,
	output logic                   grp3_pcie_disable_o,
	output logic                   display_branch_power_on_o,
	output logic      [1:0]        pll_reference_source_o,
	output logic                   fifo_write_clock_pick_o,
	output logic                   fifo_read_from_pll_b_o,
	output logic                   fifo_write_side_reset_o,
	output logic                   fifo_read_side_reset_o,
	output logic                   grp1_transmit_enable_o,
	output logic                   grp2_transmit_enable_o,
	output logic                   receive_detect_flag_o
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic [3:0] slot_of(input logic [5:0] idx);
		if (idx == IDX_PWR_MUX) begin
			slot_of = {1'b1, SLOT_PWR_MUX};
		end else if (idx == IDX_C_BACKUP) begin
			slot_of = {1'b1, SLOT_C_BACKUP};
		end else if (idx == IDX_VCO_BR) begin
			slot_of = {1'b1, SLOT_VCO_BR};
		end else if (idx == IDX_LANE_DIV) begin
			slot_of = {1'b1, SLOT_LANE_DIV};
		end else if (idx == IDX_DISP_MUX) begin
			slot_of = {1'b1, SLOT_DISP_MUX};
		end else if (idx == IDX_L47) begin
			slot_of = {1'b1, SLOT_L47};
		end else if (idx == IDX_L811) begin
			slot_of = {1'b1, SLOT_L811};
		end else if (idx == IDX_REF_DIV) begin
			slot_of = {1'b1, SLOT_REF_DIV};
		end else begin
			slot_of = 4'h0;
		end
	endfunction

	logic [31:0]           cfg_reg [NUM_SLOTS];
	logic                  pready_reg;
	logic [31:0]           prdata_reg;
	logic                  pslverr_reg;
	logic [5:0]            acc_idx;
	logic [3:0]            acc_slot;
	logic                  acc_done;
	logic                  acc_first;
	logic [31:0]           status_word;
	logic [1:0]            pll_run_reg;
	logic [1:0]            locked_reg;
	logic [LOCK_CW-1:0]    lock_cnt_reg [2];
	logic [HOLD_CW-1:0]    hold_cnt_reg;
	ddilcs_fifo_state_type fifo_state_reg;
	logic                  detect_reg;
	logic [1:0]            fifo_rst;
	logic                  path1;
	logic                  path2;

	assign acc_idx     = paddr_i[7:2];
	assign acc_slot    = slot_of(acc_idx);
	assign acc_first   = psel_i & penable_i & ~pready_reg;
	assign acc_done    = psel_i & penable_i & pready_reg;
	assign status_word = {28'h0000000, fifo_state_reg == FIFO_READY, locked_reg, detect_reg};
	assign fifo_rst    = cfg_reg[SLOT_DISP_MUX][FIFO_WRST_BIT+1:FIFO_WRST_BIT];

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			pready_reg  <= 1'b0;
			prdata_reg  <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= acc_first;
			if (acc_first) begin
				if (acc_slot[3]) begin
					prdata_reg  <= pwrite_i ? 32'h00000000 : cfg_reg[acc_slot[2:0]];
					pslverr_reg <= 1'b0;
				end else if (acc_idx == IDX_STATUS) begin
					prdata_reg  <= pwrite_i ? 32'h00000000 : status_word;
					pslverr_reg <= pwrite_i;
				end else begin
					prdata_reg  <= 32'h00000000;
					pslverr_reg <= 1'b1;
				end
			end else begin
				prdata_reg  <= 32'h00000000;
				pslverr_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < NUM_SLOTS; i++) begin
				cfg_reg[i] <= (i == int'(SLOT_DISP_MUX)) ? RST_DISP_MUX : RST_OTHER;
			end
		end else if (acc_done && pwrite_i && acc_slot[3]) begin
			cfg_reg[acc_slot[2:0]] <= pwdata_i;
		end
	end

	// ----------------------------------------------------------------
	// PLL power and lock timing per lane group
	// ----------------------------------------------------------------
	for (genvar g = 0; g < 2; g++) begin : gen_pll
		localparam logic [2:0] LSLOT = (g == 0) ? SLOT_L47 : SLOT_L811;
		localparam int         FBIT  = (g == 0) ? FORCE_G1_BIT : FORCE_G2_BIT;

		always_ff @(posedge mclk_i) begin
			if (!rstn_i) begin
				pll_run_reg[g]  <= 1'b0;
				lock_cnt_reg[g] <= '0;
				locked_reg[g]   <= 1'b0;
			end else begin
				pll_run_reg[g] <= cfg_reg[LSLOT][PLL_ON_BIT] & ~cfg_reg[SLOT_DISP_MUX][FBIT];
				if (!pll_run_reg[g]) begin
					lock_cnt_reg[g] <= '0;
					locked_reg[g]   <= 1'b0;
				end else if (lock_cnt_reg[g] == LOCK_CW'(PLL_LOCK_CYC)) begin
					locked_reg[g] <= 1'b1;
				end else begin
					lock_cnt_reg[g] <= lock_cnt_reg[g] + 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Display FIFO reset tracking
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			fifo_state_reg <= FIFO_IDLE;
			hold_cnt_reg   <= '0;
		end else begin
			case (fifo_state_reg)
				FIFO_IDLE: begin
					if (fifo_rst == FIFO_RST_ON) begin
						fifo_state_reg <= FIFO_HELD;
						hold_cnt_reg   <= HOLD_CW'(1);
					end
				end
				FIFO_HELD: begin
					if (fifo_rst == FIFO_RST_ON) begin
						if (hold_cnt_reg != '1) begin
							hold_cnt_reg <= hold_cnt_reg + 1'b1;
						end
					end else if (fifo_rst == FIFO_RST_OFF && hold_cnt_reg >= HOLD_CW'(FIFO_HOLD_CYC)) begin
						fifo_state_reg <= FIFO_READY;
					end else begin
						fifo_state_reg <= FIFO_IDLE;
					end
				end
				FIFO_READY: begin
					if (fifo_rst == FIFO_RST_ON) begin
						fifo_state_reg <= FIFO_HELD;
						hold_cnt_reg   <= HOLD_CW'(1);
					end else if (fifo_rst != FIFO_RST_OFF) begin
						fifo_state_reg <= FIFO_IDLE;
					end
				end
				default: begin
					fifo_state_reg <= FIFO_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Setup complete detection
	// ----------------------------------------------------------------
	assign path1 = grp1_display_traffic_o & grp1_channel1_fed_o & locked_reg[0] & grp1_transmit_enable_o;
	assign path2 = grp2_display_traffic_o & grp2_channel1_fed_o & locked_reg[1] & grp2_transmit_enable_o
		& grp3_pcie_disable_o;

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			detect_reg <= 1'b0;
		end else begin
			detect_reg <= (fifo_state_reg == FIFO_READY) & (path1 | path2);
		end
	end

	// ----------------------------------------------------------------
	// Registered control outputs
	// ----------------------------------------------------------------
	// Transmit and clock controls, including lane seven and eleven link clock picks and the FIFO read clock pick.
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			grp1_tx_bypass_enable_o       <= 1'b0;
			grp2_tx_bypass_enable_o       <= 1'b0;
			grp1_incoh_display_o          <= 1'b0;
			grp1_incoh_core_o             <= 1'b0;
			grp2_incoh_display_o          <= 1'b0;
			grp2_incoh_core_o             <= 1'b0;
			grp1_clock_halve_mode_o       <= 1'b0;
			grp2_clock_halve_mode_o       <= 1'b0;
			lane_seven_link_clock_pick_o  <= 1'b0;
			lane_eleven_link_clock_pick_o <= 1'b0;
			grp1_tx_from_pll_o            <= 1'b0;
			grp2_tx_from_pll_o            <= 1'b0;
			grp1_channel1_fed_o           <= 1'b0;
			grp2_channel1_fed_o           <= 1'b0;
			grp1_display_traffic_o        <= 1'b0;
			grp2_display_traffic_o        <= 1'b0;
			grp3_pcie_disable_o           <= 1'b0;
			display_branch_power_on_o     <= 1'b0;
			pll_reference_source_o        <= 2'h0;
			fifo_write_clock_pick_o       <= 1'b0;
			fifo_read_from_pll_b_o        <= 1'b0;
			fifo_write_side_reset_o       <= 1'b0;
			fifo_read_side_reset_o        <= 1'b0;
			grp1_transmit_enable_o        <= 1'b0;
			grp2_transmit_enable_o        <= 1'b0;
		end else begin
			grp1_tx_bypass_enable_o <= cfg_reg[SLOT_L47][BYPASS_BIT];
			grp2_tx_bypass_enable_o <= cfg_reg[SLOT_L811][BYPASS_BIT];
			grp1_incoh_display_o <= cfg_reg[SLOT_VCO_BR][G1_INCOH_LSB+2:G1_INCOH_LSB] == INCOH_DISPLAY;
			grp1_incoh_core_o    <= cfg_reg[SLOT_VCO_BR][G1_INCOH_LSB+2:G1_INCOH_LSB] == INCOH_CORE;
			grp2_incoh_display_o <= cfg_reg[SLOT_C_BACKUP][G2_INCOH_LSB+2:G2_INCOH_LSB] == INCOH_DISPLAY;
			grp2_incoh_core_o    <= cfg_reg[SLOT_C_BACKUP][G2_INCOH_LSB+2:G2_INCOH_LSB] == INCOH_CORE;
			grp1_clock_halve_mode_o <= cfg_reg[SLOT_L47][HALVE_BIT];
			grp2_clock_halve_mode_o <= cfg_reg[SLOT_L811][HALVE_BIT];
			lane_seven_link_clock_pick_o  <= cfg_reg[SLOT_DISP_MUX][LANE7_PICK_BIT];
			lane_eleven_link_clock_pick_o <= cfg_reg[SLOT_DISP_MUX][LANE11_PICK_BIT];
			grp1_tx_from_pll_o <= cfg_reg[SLOT_PWR_MUX][G1_TXSRC_LSB+1:G1_TXSRC_LSB] == TXSRC_PLL_B;
			grp2_tx_from_pll_o <= cfg_reg[SLOT_PWR_MUX][G2_TXSRC_LSB+1:G2_TXSRC_LSB] == TXSRC_PLL_C;
			grp1_channel1_fed_o <= ~cfg_reg[SLOT_DISP_MUX][STAGE0_BIT]
				& cfg_reg[SLOT_DISP_MUX][STAGE1_G1_BIT];
			grp2_channel1_fed_o <= ~cfg_reg[SLOT_DISP_MUX][STAGE0_BIT]
				& cfg_reg[SLOT_DISP_MUX][STAGE1_G2_BIT];
			grp1_display_traffic_o <= cfg_reg[SLOT_LANE_DIV][STAGE2_G1_BIT];
			grp2_display_traffic_o <= cfg_reg[SLOT_LANE_DIV][STAGE2_G2_BIT];
			grp3_pcie_disable_o    <= cfg_reg[SLOT_LANE_DIV][STAGE2_G3_BIT];
			display_branch_power_on_o <= cfg_reg[SLOT_VCO_BR][BRANCH0_BIT];
			pll_reference_source_o <= cfg_reg[SLOT_DISP_MUX][REF_SRC_LSB+1:REF_SRC_LSB];
			fifo_write_clock_pick_o <= cfg_reg[SLOT_DISP_MUX][WCLK_PICK_BIT];
			fifo_read_from_pll_b_o  <= cfg_reg[SLOT_PWR_MUX][RCLK_LSB+2:RCLK_LSB] == RCLK_PLL_B;
			fifo_write_side_reset_o <= fifo_rst[0];
			fifo_read_side_reset_o  <= fifo_rst[1];
			grp1_transmit_enable_o  <= cfg_reg[SLOT_L47][TX_EN_BIT];
			grp2_transmit_enable_o  <= cfg_reg[SLOT_L811][TX_EN_BIT];
		end
	end

	assign prdata_o              = prdata_reg;
	assign pready_o              = pready_reg;
	assign pslverr_o             = pslverr_reg;
	assign grp1_pll_power_on_o   = pll_run_reg[0];
	assign grp2_pll_power_on_o   = pll_run_reg[1];
	assign receive_detect_flag_o = detect_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	logic wr_done;
	assign wr_done = acc_done & pwrite_i;

	bypass_follow_a: assert property (wr_done && acc_idx == IDX_L47 |-> ##2
		grp1_tx_bypass_enable_o == $past(pwdata_i[BYPASS_BIT], 2))
		else $error("group one bypass does not follow write");
	incoh_code_a: assert property (wr_done && acc_idx == IDX_VCO_BR |-> ##2
		grp1_incoh_display_o == ($past(pwdata_i[30:28], 2) == INCOH_DISPLAY))
		else $error("incoherent display select wrong");
	lane7_pick_a: assert property (wr_done && acc_idx == IDX_DISP_MUX |-> ##2
		lane_seven_link_clock_pick_o == $past(pwdata_i[LANE7_PICK_BIT], 2))
		else $error("lane seven link pick wrong");
	txsrc_pll_a: assert property (wr_done && acc_idx == IDX_PWR_MUX |-> ##2
		grp1_tx_from_pll_o == ($past(pwdata_i[23:22], 2) == TXSRC_PLL_B))
		else $error("group one transmit source wrong");
	force_off_a: assert property (wr_done && acc_idx == IDX_DISP_MUX && pwdata_i[FORCE_G1_BIT]
		|-> ##2 !grp1_pll_power_on_o [*3])
		else $error("PLL runs while forced off");
	stage2_disp_a: assert property (wr_done && acc_idx == IDX_LANE_DIV |-> ##2
		grp2_display_traffic_o == $past(pwdata_i[STAGE2_G2_BIT], 2))
		else $error("stage two group two select wrong");
	rclk_pick_a: assert property (wr_done && acc_idx == IDX_PWR_MUX |-> ##2
		fifo_read_from_pll_b_o == ($past(pwdata_i[28:26], 2) == RCLK_PLL_B))
		else $error("FIFO read clock pick wrong");
	detect_cause_a: assert property (receive_detect_flag_o |->
		$past(fifo_state_reg) == FIFO_READY && $past(locked_reg) != 2'b00)
		else $error("detect flag without finished setup");
	short_hold_a: assert property (fifo_state_reg == FIFO_HELD && fifo_rst == FIFO_RST_OFF
		&& hold_cnt_reg < HOLD_CW'(FIFO_HOLD_CYC) |=> fifo_state_reg == FIFO_IDLE)
		else $error("short FIFO reset accepted");
	lock_wait_a: assert property ($rose(pll_run_reg[0]) |-> !locked_reg[0] [*8])
		else $error("PLL reported locked too early");

	detect_c: cover property ($rose(receive_detect_flag_o));
	fifo_ready_c: cover property ($rose(fifo_state_reg == FIFO_READY));
	lock_g1_c: cover property ($rose(locked_reg[0]));
	grp2_path_c: cover property (path2);
endmodule
`default_nettype wire

// [ddilcs_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module ddilcs_top_bench
	import ddilcs_pkg::*;
;
	// ------------------------------------------------
	// Signals
	// ------------------------------------------------
	typedef struct packed {
		logic [5:0]  idx;
		logic [31:0] data;
		logic [31:0] exp;
	} ddilcs_row_type;

	logic        mclk_i;
	logic        rstn_i;
	logic        psel_i;
	logic        penable_i;
	logic        pwrite_i;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	wire  [31:0] obs;
	int          num_errors = 0;
	int          samples_checked = 0;
	logic [31:0] rd;
	logic        err;
	logic [5:0]  regs [9] = '{IDX_PWR_MUX, IDX_C_BACKUP, IDX_VCO_BR, IDX_LANE_DIV,
		IDX_DISP_MUX, IDX_L47, IDX_L811, IDX_REF_DIV, IDX_STATUS};

	// Group one bring-up, then group two, then field boundary cases
	ddilcs_row_type rows [23] = '{
		'{IDX_L47,      32'h1000_0000, 32'h0000_0029},
		'{IDX_VCO_BR,   32'h4040_0000, 32'h0008_0025},
		'{IDX_REF_DIV,  32'h0000_0A14, 32'h0008_0025},
		'{IDX_L47,      32'h1800_0000, 32'h0008_0065},
		'{IDX_DISP_MUX, 32'h0208_0203, 32'h0028_4165},
		'{IDX_PWR_MUX,  32'h0AC0_0000, 32'h00A8_4D65},
		'{IDX_L47,      32'h1C00_0000, 32'h00A8_4D65},
		'{IDX_DISP_MUX, 32'h0208_1202, 32'h00E8_5D65},
		'{IDX_LANE_DIV, 32'h0000_0020, 32'h00E9_5D65},
		'{IDX_L47,      32'h1C00_0001, 32'h00E9_5D65},
		'{IDX_L47,      32'h1C00_0003, 32'h00E9_5D65},
		'{IDX_L47,      32'h1C00_0007, 32'h00E9_5D65},
		'{IDX_L47,      32'h1C00_000F, 32'h00E9_5D65},
		'{IDX_L47,      32'h1C00_001F, 32'h04E9_5D65},
		'{IDX_C_BACKUP, 32'h0001_0000, 32'h04E9_5D55},
		'{IDX_L811,     32'h1800_0000, 32'h04E9_5DD7},
		'{IDX_DISP_MUX, 32'h0618_1200, 32'h04E9_DFD7},
		'{IDX_LANE_DIV, 32'h0000_00E0, 32'h04EF_DFD7},
		'{IDX_VCO_BR,   32'h0040_0000, 32'h04EF_DFDB},
		'{IDX_DISP_MUX, 32'h0619_1200, 32'h04EF_1FDB},
		'{IDX_DISP_MUX, 32'h0618_1200, 32'h04EF_DFDB},
		'{IDX_PWR_MUX,  32'h0980_0000, 32'h04EF_D3DB},
		'{IDX_PWR_MUX,  32'h0AC0_0000, 32'h04EF_DFDB}
	};

	assign obs[31:29] = 3'h0;

	ddilcs_top #(.ADDR_W(8)) i_ddilcs_top (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.psel_i(psel_i),
		.penable_i(penable_i),
		.pwrite_i(pwrite_i),
		.paddr_i(paddr_i),
		.pwdata_i(pwdata_i),
		.prdata_o(prdata_o),
		.pready_o(pready_o),
		.pslverr_o(pslverr_o),
		.grp1_tx_bypass_enable_o(obs[0]),
		.grp2_tx_bypass_enable_o(obs[1]),
		.grp1_incoh_display_o(obs[2]),
		.grp1_incoh_core_o(obs[3]),
		.grp2_incoh_display_o(obs[4]),
		.grp2_incoh_core_o(obs[5]),
		.grp1_clock_halve_mode_o(obs[6]),
		.grp2_clock_halve_mode_o(obs[7]),
		.lane_seven_link_clock_pick_o(obs[8]),
		.lane_eleven_link_clock_pick_o(obs[9]),
		.grp1_tx_from_pll_o(obs[10]),
		.grp2_tx_from_pll_o(obs[11]),
		.grp1_pll_power_on_o(obs[12]),
		.grp2_pll_power_on_o(obs[13]),
		.grp1_channel1_fed_o(obs[14]),
		.grp2_channel1_fed_o(obs[15]),
		.grp1_display_traffic_o(obs[16]),
		.grp2_display_traffic_o(obs[17]),
		.grp3_pcie_disable_o(obs[18]),
		.display_branch_power_on_o(obs[19]),
		.pll_reference_source_o(obs[21:20]),
		.fifo_write_clock_pick_o(obs[22]),
		.fifo_read_from_pll_b_o(obs[23]),
		.fifo_write_side_reset_o(obs[24]),
		.fifo_read_side_reset_o(obs[25]),
		.grp1_transmit_enable_o(obs[26]),
		.grp2_transmit_enable_o(obs[27]),
		.receive_detect_flag_o(obs[28])
	);

	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end

	// ------------------------------------------------
	// Tasks
	// ------------------------------------------------
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t ns: word %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic check_err(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t ns: slave error %b, expected %b", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
			output logic [31:0] rdv, output logic errv);
		int n = 0;
		@(posedge mclk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= addr;
		pwdata_i <= wd;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge mclk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 16);
		if (n >= 16) begin
			num_errors++;
			$display("[ERR] %0t ns: no ready on bus", $time);
		end
		rdv = prdata_o;
		errv = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	// Write, read back, let derived outputs settle, compare them all
	task automatic step(input logic [5:0] idx, input logic [31:0] wd, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b1, {idx, 2'h0}, wd, r, e);
		check_err(e, 1'b0);
		apb(1'b0, {idx, 2'h0}, 32'h0, r, e);
		check_word(r, wd);
		repeat (3) @(posedge mclk_i);
		check_word(obs, exp);
	endtask

	task automatic do_reset();
		logic [31:0] r;
		logic        e;
		@(posedge mclk_i);
		rstn_i <= 1'b0;
		repeat (6) @(posedge mclk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		check_word(obs, 32'h0000_0028);
		foreach (regs[i]) begin
			apb(1'b0, {regs[i], 2'h0}, 32'h0, r, e);
			check_word(r, (regs[i] == IDX_DISP_MUX) ? RST_DISP_MUX : RST_OTHER);
		end
	endtask

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ------------------------------------------------
	// Tests
	// ------------------------------------------------
	initial begin
		rstn_i = 1'b0;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0;
		do_reset();
		foreach (rows[i]) begin
			// Lane drivers are touched only once the PLL has had its lock time
			if (i == 9) begin
				apb(1'b0, {IDX_STATUS, 2'h0}, 32'h0, rd, err);
				check_word(rd, 32'h0000_0000);
				repeat (760) @(posedge mclk_i);
				apb(1'b0, {IDX_STATUS, 2'h0}, 32'h0, rd, err);
				check_word(rd, 32'h0000_0002);
			end
			step(rows[i].idx, rows[i].data, rows[i].exp);
		end
		step(IDX_DISP_MUX, 32'h0618_120C, 32'h07EF_DFDB);
		step(IDX_DISP_MUX, 32'h0618_1200, 32'h14EF_DFDB);
		apb(1'b0, {IDX_STATUS, 2'h0}, 32'h0, rd, err);
		check_word(rd, 32'h0000_000B);
		// Partial release must not count as a clean release
		step(IDX_DISP_MUX, 32'h0618_120C, 32'h07EF_DFDB);
		step(IDX_DISP_MUX, 32'h0618_1204, 32'h05EF_DFDB);
		step(IDX_DISP_MUX, 32'h0618_1200, 32'h04EF_DFDB);
		apb(1'b0, {IDX_STATUS, 2'h0}, 32'h0, rd, err);
		check_word(rd, 32'h0000_0002);
		apb(1'b1, 8'h40, 32'hFFFF_FFFF, rd, err);
		check_err(err, 1'b1);
		apb(1'b0, 8'h40, 32'h0, rd, err);
		check_err(err, 1'b1);
		check_word(rd, 32'h0000_0000);
		apb(1'b1, {IDX_STATUS, 2'h0}, 32'hFFFF_FFFF, rd, err);
		check_err(err, 1'b1);
		apb(1'b0, {IDX_STATUS, 2'h0}, 32'h0, rd, err);
		check_word(rd, 32'h0000_0002);
		do_reset();
		test_done();
	end

	initial begin
		#(4000 * 40);
		num_errors++;
		$display("[ERR] %0t ns: run did not finish", $time);
		test_done();
	end
endmodule
`default_nettype wire
